// ---- verilog/oms_consts.vh ----
// Constants for the operating mode select block
`ifndef OMS_CONSTS_VH
`define OMS_CONSTS_VH

// Register byte address: word index times four on the 32-bit bus
`define OMS_MODE_INDEX      8'h0B
`define OMS_MODE_ADDR       10'h02C

// Field positions in the mode register
`define OMS_BIT_NORMAL      7
`define OMS_BIT_SEL_B       6
`define OMS_BIT_SEL_A       5
`define OMS_BIT_STRETCH     4
`define OMS_BIT_VIS         3
`define OMS_BIT_BUS_STOP    2
`define OMS_BIT_ZERO        1
`define OMS_BIT_EMUL_E      0

// Reset values of the low option bits
`define OMS_OPT_RST_SPECIAL 5'h19
`define OMS_OPT_RST_NORMAL  5'h10

// Mode codes: normal flag, select B, select A
`define OMS_M_NSC           3'h4
`define OMS_M_NEN           3'h5
`define OMS_M_RSV           3'h6
`define OMS_M_NEW           3'h7
`define OMS_M_SSC           3'h0
`define OMS_M_SEN           3'h1
`define OMS_M_SPR           3'h2
`define OMS_M_SEW           3'h3

// Debug map windows
`define OMS_DBG_ROM_LO      16'hFF20
`define OMS_DBG_REG_LO      16'hFF00
`define OMS_DBG_REG_HI      16'hFF06

`endif

// ---- verilog/oms_narrow_seq.v ----
// Narrow-bus sequencer splitting a 16-bit transfer into two byte cycles
`timescale 1ns/1ps
`default_nettype none

module oms_narrow_seq (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Request
    input  wire        req,
    input  wire        narrow,
    input  wire [15:0] addr,
    input  wire [15:0] wdata,
    // Bus side
    output reg  [15:0] bus_addr_reg,
    output reg  [7:0]  bus_data_reg,
    output reg         bus_valid_reg,
    output reg         busy_reg
);
    reg        second_reg;
    reg [7:0]  low_reg;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_addr_reg  <= 16'h0000;
            bus_data_reg  <= 8'h00;
            bus_valid_reg <= 1'b0;
            busy_reg      <= 1'b0;
            second_reg    <= 1'b0;
            low_reg       <= 8'h00;
        end else if (second_reg) begin
            bus_addr_reg  <= bus_addr_reg + 16'h0001;
            bus_data_reg  <= low_reg;
            second_reg    <= 1'b0;
            busy_reg      <= 1'b0;
        end else if (req && !busy_reg) begin
            bus_addr_reg  <= addr;
            bus_valid_reg <= 1'b1;
            bus_data_reg  <= narrow ? wdata[15:8] : wdata[7:0];
            low_reg       <= wdata[7:0];
            second_reg    <= narrow;
            busy_reg      <= narrow;
        end else begin
            bus_valid_reg <= 1'b0;
        end
    end
endmodule // oms_narrow_seq

`default_nettype wire

// ---- verilog/oms_mode_select.v ----
// Operating mode select with mode register on classic Wishbone
`timescale 1ns/1ps
`default_nettype none
`include "oms_consts.vh"

// Operation
// - Capture debug and mode pins at reset release
// - Decode eight modes, reserved forced to peripheral
// - Single chip: no external bus, ports GPIO
// - Expanded wide: ports A and B 16-bit
// - Narrow: byte data on A, high first
// - Second narrow byte uses address plus one
// - Normal modes protect bits, special allows more
// - Special single chip starts debug active
// - Peripheral mode: processor idle, reset only
// - Otherwise debug enabled, then command or instruction
// - Active debug maps ROM and debug registers
// - Active debug supplies vectors, hides user top
// - Mode register layout and mode-dependent reset
// - Mode register unmapped in peripheral mode
// - Mode bits read current captured mode
// - Normal flag written in special, first ignored
// - Select bits once normal, special after first
// - Refuse writes selecting peripheral or reserved
// - Stretch enable reads one when expanded
// - Visibility once normal, special after first
// - Bus stop writable normal, never special
// - Emulate port E unmaps port E when expanded
module oms_mode_select (
    // Clock and reset
    input  wire        core_clk,
    input  wire        rst_n,
    // Mode pins
    input  wire        debug_pin,
    input  wire        mode_select_b,
    input  wire        mode_select_a,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [9:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Debug control
    input  wire        debug_enable,
    input  wire        debug_serial_cmd,
    input  wire        halt_to_debug_instr,
    input  wire        debug_exit,
    // Core address for map decode
    input  wire [15:0] core_addr,
    // External transfer request
    input  wire        ext_req,
    input  wire [15:0] ext_addr,
    input  wire [15:0] ext_wdata,
    // Mode outputs
    output reg         normal_mode_reg,
    output reg         single_chip_reg,
    output reg         expanded_wide_reg,
    output reg         expanded_narrow_reg,
    output reg         peripheral_mode_reg,
    output reg         cpu_halt_reg,
    output reg         protect_reg,
    output reg         background_debug_reg,
    output reg         dbg_rom_sel_reg,
    output reg         dbg_regs_sel_reg,
    output reg         user_top_hidden_reg,
    output reg         port_e_mapped_reg,
    output reg         clock_stretch_reg,
    output reg         vis_active_reg,
    output reg         bus_stop_wait_reg,
    // External bus
    output reg  [15:0] ext_bus_addr_reg,
    output reg  [15:0] ext_bus_data_reg,
    output reg         ext_bus_valid_reg,
    output reg         ext_busy_reg
);
    // Pin synchronisers
    reg  [2:0] pin_s1_reg;
    reg  [2:0] pin_s2_reg;
    reg        started_reg;
    reg  [2:0] mode_reg;
    reg        stretch_reg;
    reg        vis_reg;
    reg        bstop_reg;
    reg        emul_reg;
    reg        wr_seen_reg;
    reg        sel_wr_once_reg;
    reg        stretch_once_reg;
    reg        vis_once_reg;
    reg        emul_once_reg;
    reg        dbg_reg;

    wire [15:0] ns_addr;
    wire [7:0]  ns_data;
    wire        ns_valid;
    wire        ns_busy;

    function is_special;
        input [2:0] m;
        begin
            // Reserved code is forced to peripheral, which is a special mode
            is_special = ~m[2] || (m == `OMS_M_RSV);
        end
    endfunction

    function is_single;
        input [2:0] m;
        begin
            is_single = (m[1:0] == 2'b00);
        end
    endfunction

    function is_periph;
        input [2:0] m;
        begin
            is_periph = (m == `OMS_M_SPR) || (m == `OMS_M_RSV);
        end
    endfunction

    function is_wide;
        input [2:0] m;
        begin
            is_wide = (m[1:0] == 2'b11);
        end
    endfunction

    function is_narrow;
        input [2:0] m;
        begin
            is_narrow = (m[1:0] == 2'b01);
        end
    endfunction

    wire       special   = is_special(mode_reg);
    wire       expanded  = is_wide(mode_reg) | is_narrow(mode_reg);
    wire       reg_hit   = (wb_adr_i == `OMS_MODE_ADDR) && !is_periph(mode_reg);
    wire       wb_req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire       wr        = wb_req && wb_we_i && wb_sel_i[0] && reg_hit;
    wire [7:0] wd        = wb_dat_i[7:0];
    wire [2:0] new_mode  = {wd[`OMS_BIT_NORMAL], wd[`OMS_BIT_SEL_B], wd[`OMS_BIT_SEL_A]};
    wire       first_wr  = !wr_seen_reg;
    wire [7:0] mode_byte = {mode_reg, (expanded | stretch_reg), vis_reg, bstop_reg,
                            1'b0, emul_reg};

    // Mode and option next values
    reg  [2:0] mode_next;
    reg        stretch_next;
    reg        vis_next;
    reg        bstop_next;
    reg        emul_next;

    always @* begin
        mode_next    = mode_reg;
        stretch_next = stretch_reg;
        vis_next     = vis_reg;
        bstop_next   = bstop_reg;
        emul_next    = emul_reg;
        if (special) begin
            if (!first_wr) begin
                mode_next[2]   = wd[`OMS_BIT_NORMAL];
                mode_next[1:0] = new_mode[1:0];
                vis_next       = wd[`OMS_BIT_VIS];
                emul_next      = wd[`OMS_BIT_EMUL_E];
            end
            stretch_next = wd[`OMS_BIT_STRETCH];
        end else begin
            if (!sel_wr_once_reg) begin
                mode_next[1:0] = new_mode[1:0];
            end
            if (!stretch_once_reg) begin
                stretch_next = wd[`OMS_BIT_STRETCH];
            end
            if (!vis_once_reg) begin
                vis_next = wd[`OMS_BIT_VIS];
            end
            if (!emul_once_reg) begin
                emul_next = wd[`OMS_BIT_EMUL_E];
            end
            bstop_next = wd[`OMS_BIT_BUS_STOP];
        end
        if (is_periph(mode_next)) begin
            mode_next = mode_reg;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
        end else begin
            pin_s1_reg <= {debug_pin, mode_select_b, mode_select_a};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Pins are caught on the third edge after release: both synchroniser stages
    // start from reset, so the strap level only reaches the second stage on edge two
    reg [1:0] cap_cnt_reg;
    wire [4:0] opt_rst = pin_s2_reg[2] ? `OMS_OPT_RST_NORMAL : `OMS_OPT_RST_SPECIAL;

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cap_cnt_reg      <= 2'h0;
            started_reg      <= 1'b0;
            mode_reg         <= 3'h0;
            stretch_reg      <= 1'b1;
            vis_reg          <= 1'b0;
            bstop_reg        <= 1'b0;
            emul_reg         <= 1'b0;
            wr_seen_reg      <= 1'b0;
            sel_wr_once_reg  <= 1'b0;
            stretch_once_reg <= 1'b0;
            vis_once_reg     <= 1'b0;
            emul_once_reg    <= 1'b0;
            wb_ack_o         <= 1'b0;
            wb_dat_o         <= 32'h0000_0000;
        end else if (!started_reg) begin
            cap_cnt_reg <= cap_cnt_reg + 2'h1;
            if (cap_cnt_reg == 2'h2) begin
                started_reg <= 1'b1;
                mode_reg    <= pin_s2_reg;
                // Bit one is the constant zero field and has no storage
                {stretch_reg, vis_reg, bstop_reg, emul_reg} <= {opt_rst[4:2], opt_rst[0]};
            end
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i && reg_hit) begin
                wb_dat_o <= {24'h00_0000, mode_byte};
            end
            if (wr) begin
                wr_seen_reg <= 1'b1;
                mode_reg    <= mode_next;
                stretch_reg <= stretch_next;
                vis_reg     <= vis_next;
                bstop_reg   <= bstop_next;
                emul_reg    <= emul_next;
                if (!special) begin
                    sel_wr_once_reg  <= 1'b1;
                    stretch_once_reg <= 1'b1;
                    vis_once_reg     <= 1'b1;
                    emul_once_reg    <= 1'b1;
                end
            end
        end
    end

    // Debug state: special single chip starts active
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dbg_reg <= 1'b0;
        end else if (!started_reg) begin
            dbg_reg <= (cap_cnt_reg == 2'h2) && (pin_s2_reg == `OMS_M_SSC);
        end else if (debug_exit) begin
            dbg_reg <= 1'b0;
        end else if (debug_enable && (debug_serial_cmd || halt_to_debug_instr)) begin
            dbg_reg <= 1'b1;
        end
    end

    // Registered mode outputs
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            normal_mode_reg      <= 1'b0;
            single_chip_reg      <= 1'b0;
            expanded_wide_reg    <= 1'b0;
            expanded_narrow_reg  <= 1'b0;
            peripheral_mode_reg  <= 1'b0;
            cpu_halt_reg         <= 1'b1;
            protect_reg          <= 1'b0;
            background_debug_reg <= 1'b0;
            dbg_rom_sel_reg      <= 1'b0;
            dbg_regs_sel_reg     <= 1'b0;
            user_top_hidden_reg  <= 1'b0;
            port_e_mapped_reg    <= 1'b1;
            clock_stretch_reg    <= 1'b0;
            vis_active_reg       <= 1'b0;
            bus_stop_wait_reg    <= 1'b0;
        end else begin
            normal_mode_reg      <= started_reg & ~special;
            single_chip_reg      <= started_reg & is_single(mode_reg);
            expanded_wide_reg    <= started_reg & is_wide(mode_reg);
            expanded_narrow_reg  <= started_reg & is_narrow(mode_reg);
            peripheral_mode_reg  <= started_reg & is_periph(mode_reg);
            cpu_halt_reg         <= !started_reg | is_periph(mode_reg);
            protect_reg          <= started_reg & ~special;
            background_debug_reg <= dbg_reg;
            dbg_rom_sel_reg      <= dbg_reg && (core_addr >= `OMS_DBG_ROM_LO);
            dbg_regs_sel_reg     <= dbg_reg && (core_addr >= `OMS_DBG_REG_LO)
                                    && (core_addr <= `OMS_DBG_REG_HI);
            user_top_hidden_reg  <= dbg_reg && (core_addr >= `OMS_DBG_REG_LO);
            port_e_mapped_reg    <= !(expanded && emul_reg) && !is_periph(mode_reg);
            clock_stretch_reg    <= expanded | stretch_reg;
            vis_active_reg       <= vis_reg & ~is_single(mode_reg);
            bus_stop_wait_reg    <= bstop_reg;
        end
    end

    oms_narrow_seq u_narrow (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .req           (ext_req && expanded && started_reg),
        .narrow        (is_narrow(mode_reg)),
        .addr          (ext_addr),
        .wdata         (ext_wdata),
        .bus_addr_reg  (ns_addr),
        .bus_data_reg  (ns_data),
        .bus_valid_reg (ns_valid),
        .busy_reg      (ns_busy)
    );

    // External bus outputs; wide mode carries the full word
    reg [15:0] wide_data_reg;
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wide_data_reg <= 16'h0000;
        end else if (ext_req && !ns_busy) begin
            wide_data_reg <= ext_wdata;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_bus_addr_reg  <= 16'h0000;
            ext_bus_data_reg  <= 16'h0000;
            ext_bus_valid_reg <= 1'b0;
            ext_busy_reg      <= 1'b0;
        end else begin
            ext_bus_addr_reg  <= ns_addr;
            ext_bus_data_reg  <= is_wide(mode_reg) ? wide_data_reg : {8'h00, ns_data};
            ext_bus_valid_reg <= ns_valid;
            ext_busy_reg      <= ns_busy;
        end
    end
endmodule // oms_mode_select

`default_nettype wire

// ---- verification/oms_ext_bus_model.sv ----
// Far-side memory that logs the first 16 phases seen on the external bus
`timescale 1ns/1ps
`default_nettype none
module oms_ext_bus_model (
    // Clock
    input wire logic        core_clk,
    // Multiplexed bus
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_data,
    input wire logic        bus_valid
);
    logic [15:0] log_addr [0:15];
    logic [15:0] log_data [0:15];
    int          n_phases = 0;
    // A narrow transfer shows up as two phases, a wide one as one
    always @(posedge core_clk) begin
        if (bus_valid === 1'b1 && n_phases < 16) begin
            log_addr[n_phases] <= bus_addr;
            log_data[n_phases] <= bus_data;
            n_phases <= n_phases + 1;
        end
    end
endmodule // oms_ext_bus_model
`default_nettype wire

// ---- verification/oms_mode_select_properties.sv ----
// Concurrent checks on the mode select ports
`timescale 1ns/1ps
`default_nettype none
module oms_mode_select_properties (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Mode and map
    input wire logic [15:0] core_addr,
    input wire logic        single_chip_reg,
    input wire logic        expanded_wide_reg,
    input wire logic        expanded_narrow_reg,
    input wire logic        peripheral_mode_reg,
    input wire logic        cpu_halt_reg,
    input wire logic        background_debug_reg,
    input wire logic        dbg_rom_sel_reg,
    input wire logic [15:0] ext_bus_addr_reg,
    input wire logic        ext_bus_valid_reg
);
    logic [2:0] up_cnt_reg;
    logic       live;
    // Startup needs a few edges before the mode outputs mean anything
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n)
            up_cnt_reg <= 3'h0;
        else if (up_cnt_reg != 3'h7)
            up_cnt_reg <= up_cnt_reg + 3'h1;
    end
    assign live = (up_cnt_reg == 3'h7);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence hi_byte_s;
        $rose(ext_bus_valid_reg) && expanded_narrow_reg;
    endsequence
    sequence lo_byte_s;
        ext_bus_valid_reg && ext_bus_addr_reg == $past(ext_bus_addr_reg) + 16'h0001;
    endsequence
    req_ack_a: assert property (live && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    read_pad_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000 && !wb_dat_o[1])
        else $error("read data has nonzero pad bits");
    stretch_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 10'h02c && wb_sel_i[0]
        && (expanded_wide_reg || expanded_narrow_reg) |-> wb_dat_o[4])
        else $error("stretch bit reads zero in expanded mode");
    periph_read_a: assert property (wb_ack_o && !wb_we_i && peripheral_mode_reg
        |-> wb_dat_o == 32'h0000_0000)
        else $error("mode register visible in peripheral mode");
    periph_halt_a: assert property (live && peripheral_mode_reg |-> cpu_halt_reg)
        else $error("processor running in peripheral mode");
    mode_onehot_a: assert property (live |-> $onehot({single_chip_reg, expanded_wide_reg,
        expanded_narrow_reg, peripheral_mode_reg}))
        else $error("bus configuration not exactly one");
    rom_window_a: assert property (live && $stable(core_addr) && $stable(background_debug_reg)
        |-> dbg_rom_sel_reg == (background_debug_reg && core_addr >= 16'hff20))
        else $error("debug rom select wrong");
    narrow_pair_a: assert property (hi_byte_s |=> lo_byte_s)
        else $error("second narrow byte lacks address plus one");
endmodule // oms_mode_select_properties
bind oms_mode_select oms_mode_select_properties oms_mode_select_properties_inst (.*);
`default_nettype wire

// ---- verification/test_operating_mode_select.sv ----
// Self-checking bench for the operating mode select block
`timescale 1ns/1ps
`default_nettype none
`include "oms_consts.vh"
module test_operating_mode_select;
    logic        core_clk, rst_n, debug_pin, mode_select_b, mode_select_a;
    logic        wb_cyc_i, wb_stb_i, wb_we_i;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, rd;
    logic        debug_enable, debug_serial_cmd, halt_to_debug_instr, debug_exit, ext_req;
    logic [15:0] core_addr, ext_addr, ext_wdata;
    logic [2:0]  cd;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, normal_mode_reg, single_chip_reg, expanded_wide_reg;
    wire         expanded_narrow_reg, peripheral_mode_reg, cpu_halt_reg, protect_reg;
    wire         background_debug_reg, dbg_rom_sel_reg, dbg_regs_sel_reg, user_top_hidden_reg;
    wire         port_e_mapped_reg, clock_stretch_reg, vis_active_reg, bus_stop_wait_reg;
    wire         ext_bus_valid_reg, ext_busy_reg;
    wire  [15:0] ext_bus_addr_reg, ext_bus_data_reg;
    int          num_errors = 0;
    int          n_checks = 0;
    int          n0;

    always #10 core_clk = ~core_clk;

    oms_mode_select oms_mode_select_inst (.*);
    oms_ext_bus_model bm (
        .core_clk  (core_clk),
        .bus_addr  (ext_bus_addr_reg),
        .bus_data  (ext_bus_data_reg),
        .bus_valid (ext_bus_valid_reg)
    );

    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Classic single cycle; held until ack is seen at an edge
    task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'h1;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 16) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic wc(input logic [7:0] w, input logic [7:0] e);
        wb(1'b1, `OMS_MODE_ADDR, {24'h00_0000, w});
        wb(1'b0, `OMS_MODE_ADDR, 32'h0000_0000);
        chk("mode_reg", rd, {24'h00_0000, e});
    endtask

    // Straps stay put well past the capture point
    task automatic restart(input logic [2:0] code);
        @(posedge core_clk);
        rst_n <= 1'b0;
        {debug_pin, mode_select_b, mode_select_a} <= code;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask

    task automatic xfer;
        n0 = bm.n_phases;
        @(posedge core_clk);
        ext_req   <= 1'b1;
        ext_addr  <= 16'h12f0;
        ext_wdata <= 16'ha5c3;
        @(posedge core_clk);
        ext_req <= 1'b0;
        repeat (6) @(posedge core_clk);
    endtask

    task automatic pulse(input int which);
        @(posedge core_clk);
        debug_serial_cmd    <= (which == 0);
        halt_to_debug_instr <= (which == 1);
        debug_exit          <= (which == 2);
        @(posedge core_clk);
        {debug_serial_cmd, halt_to_debug_instr, debug_exit} <= 3'h0;
        repeat (3) @(posedge core_clk);
    endtask

    task automatic win(input logic [15:0] a, input logic on);
        @(posedge core_clk);
        core_addr <= a;
        repeat (3) @(posedge core_clk);
        chk("rom_sel", dbg_rom_sel_reg, on && a >= `OMS_DBG_ROM_LO);
        chk("regs_sel", dbg_regs_sel_reg, on && a >= `OMS_DBG_REG_LO && a <= `OMS_DBG_REG_HI);
        chk("top_hidden", user_top_hidden_reg, on && a >= `OMS_DBG_REG_LO);
    endtask

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {debug_pin, mode_select_b, mode_select_a, wb_cyc_i, wb_stb_i, wb_we_i} = 6'h00;
        {debug_enable, debug_serial_cmd, halt_to_debug_instr, debug_exit, ext_req} = 5'h00;
        wb_adr_i = 10'h000;
        wb_sel_i = 4'h1;
        wb_dat_i = 32'h0000_0000;
        {core_addr, ext_addr, ext_wdata} = 48'h0000_0000_0000;
        // No debug traffic during the strap sweep, peripheral mode included
        for (int c = 0; c < 8; c++) begin
            cd = c[2:0];
            restart(cd);
            wb(1'b0, `OMS_MODE_ADDR, 32'h0000_0000);
            chk("mode_reg", rd, (cd[1:0] == 2'b10) ? 32'h0000_0000 : {24'h00_0000, cd,
                cd[2] ? `OMS_OPT_RST_NORMAL : `OMS_OPT_RST_SPECIAL});
            chk("single", single_chip_reg, cd[1:0] == 2'b00);
            chk("wide", expanded_wide_reg, cd[1:0] == 2'b11);
            chk("narrow", expanded_narrow_reg, cd[1:0] == 2'b01);
            chk("periph", peripheral_mode_reg, cd[1:0] == 2'b10);
            chk("normal", normal_mode_reg, cd[2] && cd != 3'h6);
            chk("protect", protect_reg, cd[2] && cd != 3'h6);
            chk("debug", background_debug_reg, cd == 3'h0);
            chk("port_e", port_e_mapped_reg, !(cd[0] && !cd[2]) && cd[1:0] != 2'b10);
            chk("vis", vis_active_reg, !cd[2] && cd[1:0] != 2'b00);
            chk("halt", cpu_halt_reg, cd[1:0] == 2'b10);
            chk("stretch", clock_stretch_reg, 1'b1);
            xfer();
            chk("phases", bm.n_phases - n0, cd[0] ? (cd[1] ? 1 : 2) : 0);
            chk("busy", ext_busy_reg, 1'b0);
            if (cd[0]) begin
                chk("addr", bm.log_addr[n0], 16'h12f0);
                chk("data_hi", cd[1] ? bm.log_data[n0][15:8] : bm.log_data[n0][7:0], 8'ha5);
                chk("data_lo", cd[1] ? bm.log_data[n0][7:0] : bm.log_data[n0 + 1][7:0], 8'hc3);
                if (!cd[1])
                    chk("addr_inc", bm.log_addr[n0 + 1], 16'h12f1);
            end
        end
        restart(3'h1);
        wc(8'h79, 8'h39);
        wc(8'h79, 8'h79);
        chk("wide", expanded_wide_reg, 1'b1);
        wc(8'h59, 8'h79);
        wc(8'h7f, 8'h79);
        wc(8'h71, 8'h71);
        wc(8'hd1, 8'h71);
        wc(8'hf0, 8'hf0);
        chk("normal", normal_mode_reg, 1'b1);
        chk("port_e", port_e_mapped_reg, 1'b1);
        restart(3'h4);
        wc(8'hb4, 8'hb4);
        chk("stop_wait", bus_stop_wait_reg, 1'b1);
        wc(8'h90, 8'hb0);
        wc(8'h3c, 8'hb4);
        wb(1'b1, 10'h030, 32'h0000_00ff);
        wb(1'b0, 10'h030, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        wc(8'hb4, 8'hb4);
        pulse(0);
        chk("debug", background_debug_reg, 1'b0);
        debug_enable <= 1'b1;
        pulse(0);
        chk("debug", background_debug_reg, 1'b1);
        win(16'hff1f, 1'b1);
        win(16'hff20, 1'b1);
        win(16'hff06, 1'b1);
        win(16'hff07, 1'b1);
        pulse(2);
        chk("debug", background_debug_reg, 1'b0);
        win(16'hff20, 1'b0);
        pulse(1);
        chk("debug", background_debug_reg, 1'b1);
        tally_and_finish();
    end
endmodule // test_operating_mode_select
`default_nettype wire
